// >>> logic/asp_pkg.sv
// package of the accumulator, shift and saturate datapath
// assumes one clock, synchronous active-high reset, apb register access
package asp_pkg;
   // =====================================================
   // widths
   localparam int unsigned WORD_W = 16;
   localparam int unsigned ACC_W = 32;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned EV_W = 2;
   // =====================================================
   // register byte offsets
   localparam logic [7:0] OFS_STATUS_A = 8'h00;
   localparam logic [7:0] OFS_STATUS_B = 8'h04;
   localparam logic [7:0] OFS_OPERAND = 8'h08;
   localparam logic [7:0] OFS_PRODUCT = 8'h0c;
   localparam logic [7:0] OFS_ACC = 8'h10;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
   localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
   localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
   // =====================================================
   // field positions
   localparam int unsigned POS_OV = 12;
   localparam int unsigned POS_OVM = 11;
   localparam int unsigned POS_TC = 11;
   localparam int unsigned POS_SXM = 10;
   localparam int unsigned EV_OV = 0;
   localparam int unsigned EV_TC = 1;
   // =====================================================
   // reset values
   localparam logic [15:0] RST_STATUS_A = 16'h0000;
   localparam logic [15:0] RST_STATUS_B = 16'h0000;
   localparam logic [EV_W-1:0] RST_IRQ_EN = 2'h0;
   // =====================================================
   // encodings and limits
   localparam logic [1:0] PM_NONE = 2'h0;
   localparam logic [1:0] PM_LEFT1 = 2'h1;
   localparam logic [1:0] PM_LEFT4 = 2'h2;
   localparam logic [1:0] PM_RIGHT6 = 2'h3;
   localparam logic [31:0] ACC_MAX = 32'h7fffffff;
   localparam logic [31:0] ACC_MIN = 32'h80000000;
   localparam logic [4:0] IN_SHIFT_MAX = 5'h10;

   typedef enum logic [3:0] {
      OP_LOAD_OPERAND, OP_MUL, OP_LOAD_ACC, OP_ADD, OP_SUB, OP_ADD_PROD,
      OP_SHIFT_ACC, OP_STORE_ACC, OP_BIT_TEST, OP_STORE_ST_A, OP_STORE_ST_B,
      OP_LOAD_ST_A, OP_LOAD_ST_B, OP_CLEAR_OV
   } asp_op_type;
endpackage : asp_pkg

// >>> logic/asp_dp_if.sv
// signals between the datapath core and its shifter block
// assumes both ends sit in the same clock domain; all signals combinational
interface asp_dp_if;
   logic [31:0] product;
   logic [1:0] pm;
   logic [31:0] prod_shifted;
   logic [31:0] acc;
   logic [2:0] out_count;
   logic out_upper;
   logic [15:0] out_word;
   logic [15:0] in_word;
   logic [4:0] in_count;
   logic sign_extend_enable;
   logic [31:0] in_result;
   modport core (output product, pm, acc, out_count, out_upper, in_word, in_count, sign_extend_enable,
      input prod_shifted, out_word, in_result);
   modport shifter (input product, pm, acc, out_count, out_upper, in_word, in_count, sign_extend_enable,
      output prod_shifted, out_word, in_result);
endinterface : asp_dp_if

// >>> logic/asp_shift.sv
// product, output and input shifters of the datapath, purely combinational
// assumes the core registers product and acc; counts, select and in_word come from op inputs, in_count from operand_q when sel is high
module asp_shift (
   asp_dp_if.shifter dp // shifter side of the datapath link
);
   import asp_pkg::*;

   // =====================================================
   // product shifter
   logic signed [31:0] prod_signed;
   assign prod_signed = dp.product;
   assign dp.prod_shifted = (dp.pm == PM_LEFT1) ? {dp.product[30:0], 1'b0} :
                            (dp.pm == PM_LEFT4) ? {dp.product[27:0], 4'h0} :
                            (dp.pm == PM_RIGHT6) ? 32'(prod_signed >>> 6) :
                            dp.product;

   // =====================================================
   // output shifter: left 0..7, then one half
   logic [31:0] out_shifted;
   assign out_shifted = dp.acc << dp.out_count;
   assign dp.out_word = dp.out_upper ? out_shifted[31:16] : out_shifted[15:0];

   // =====================================================
   // input shifter: counts above 16 clamp to 16
   logic [31:0] in_ext;
   logic [4:0] in_cnt;
   assign in_ext = dp.sign_extend_enable ? {{16{dp.in_word[15]}}, dp.in_word} : {16'h0000, dp.in_word};
   assign in_cnt = (dp.in_count > IN_SHIFT_MAX) ? IN_SHIFT_MAX : dp.in_count;
   assign dp.in_result = in_ext << in_cnt;
endmodule : asp_shift

// >>> logic/asp_core.sv
// top of the accumulator, shift and saturate datapath with its apb registers
// assumes decode logic issues one op per enabled clock and holds op inputs valid with op_valid_i
//
// The placing of the registers and the APB slave port were left to the implementer.
module asp_core (
   input wire logic sys_clk_i, // 250 mhz clock
   input wire logic sys_rst_i, // synchronous reset, high
   input wire logic ce_i, // clock enable, freezes state when low
   input wire logic op_valid_i, // op strobe from decode
   input wire asp_pkg::asp_op_type op_code_i, // operation
   input wire logic [15:0] op_data_i, // operand word from data read bus
   input wire logic [4:0] op_shift_i, // static shift count
   input wire logic op_sel_i, // op qualifier, see handover
   output logic [15:0] data_write_bus_o, // stored word
   output logic data_write_valid_o, // stored word strobe
   output logic [31:0] acc_o, // accumulator
   output logic test_flag_o, // test flag
   output logic overflow_flag_o, // overflow flag
   output logic irq_o, // level interrupt
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [asp_pkg::ADDR_W-1:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready
   output logic pslverr_o // apb error on unmapped address
);
   import asp_pkg::*;

   // =====================================================
   // state
   logic [15:0] status_a_q, status_a_d;
   logic [15:0] status_b_q, status_b_d;
   logic [15:0] operand_q, operand_d;
   logic [31:0] product_q, product_d;
   logic [31:0] acc_q, acc_d;
   logic [15:0] wbus_q, wbus_d;
   logic wvalid_q;
   logic [EV_W-1:0] irq_stat_q, irq_stat_d;
   logic [EV_W-1:0] irq_en_q, irq_en_d;
   logic [31:0] rdata_q;

   asp_dp_if dp ();
   asp_shift u_shift (.dp(dp));

   // =====================================================
   // op decode
   logic do_mul, do_load, do_add, do_sub, do_addp, do_shacc, do_store, do_bit;
   logic do_st_a, do_st_b, do_ld_a, do_ld_b, do_clr_ov, do_ldop, act;
   assign act = ce_i & op_valid_i;
   assign do_ldop = act & (op_code_i == OP_LOAD_OPERAND);
   assign do_mul = act & (op_code_i == OP_MUL);
   assign do_load = act & (op_code_i == OP_LOAD_ACC);
   assign do_add = act & (op_code_i == OP_ADD);
   assign do_sub = act & (op_code_i == OP_SUB);
   assign do_addp = act & (op_code_i == OP_ADD_PROD);
   assign do_shacc = act & (op_code_i == OP_SHIFT_ACC);
   assign do_store = act & (op_code_i == OP_STORE_ACC);
   assign do_bit = act & (op_code_i == OP_BIT_TEST);
   assign do_st_a = act & (op_code_i == OP_STORE_ST_A);
   assign do_st_b = act & (op_code_i == OP_STORE_ST_B);
   assign do_ld_a = act & (op_code_i == OP_LOAD_ST_A);
   assign do_ld_b = act & (op_code_i == OP_LOAD_ST_B);
   assign do_clr_ov = act & (op_code_i == OP_CLEAR_OV);

   // =====================================================
   // mode bits
   logic saturate_enable, sign_extend_enable, ov;
   logic [1:0] pm;
   assign saturate_enable = status_a_q[POS_OVM];
   assign ov = status_a_q[POS_OV];
   assign sign_extend_enable = status_b_q[POS_SXM];
   assign pm = status_b_q[1:0];

   // =====================================================
   // shifter link
   assign dp.product = product_q;
   assign dp.pm = pm;
   assign dp.acc = acc_q;
   assign dp.out_count = op_shift_i[2:0];
   assign dp.out_upper = op_sel_i;
   assign dp.in_word = op_data_i;
   assign dp.in_count = op_sel_i ? {1'b0, operand_q[3:0]} : op_shift_i;
   assign dp.sign_extend_enable = sign_extend_enable;

   // =====================================================
   // multiplier, sel high picks signed operands
   logic signed [16:0] mul_a, mul_b;
   logic signed [33:0] mul_full;
   logic [31:0] product;
   assign mul_a = op_sel_i ? {op_data_i[15], op_data_i} : {1'b0, op_data_i};
   assign mul_b = op_sel_i ? {operand_q[15], operand_q} : {1'b0, operand_q};
   assign mul_full = mul_a * mul_b;
   assign product = mul_full[31:0];

   // =====================================================
   // accumulator arithmetic, 33 bits to see overflow
   logic [31:0] addend;
   logic [32:0] sum;
   logic arith, ovf, ovf_neg;
   logic [31:0] sat_val, shacc;
   assign addend = do_addp ? dp.prod_shifted : dp.in_result;
   assign sum = do_sub ? {acc_q[31], acc_q} - {addend[31], addend}
                       : {acc_q[31], acc_q} + {addend[31], addend};
   assign arith = do_add | do_sub | do_addp;
   assign ovf = arith & (sum[32] != sum[31]);
   assign ovf_neg = sum[32];
   assign sat_val = ovf_neg ? ACC_MIN : ACC_MAX;
   // sel high shifts right; the msb fills with the sign bit when sign extension is on, else with zero
   assign shacc = op_sel_i ? {sign_extend_enable & acc_q[31], acc_q[31:1]} : {acc_q[30:0], 1'b0};

   // =====================================================
   // bit test, index counts from the lsb
   logic [3:0] bit_idx;
   logic bit_val;
   assign bit_idx = op_sel_i ? operand_q[3:0] : op_shift_i[3:0];
   assign bit_val = op_data_i[bit_idx];

   // =====================================================
   // apb decode, no wait states; read data caught in setup
   logic setup, access, wr, mapped;
   logic [31:0] rsel;
   assign setup = psel_i & ~penable_i;
   assign access = psel_i & penable_i & ce_i;
   assign wr = access & pwrite_i;
   assign mapped = (paddr_i[1:0] == 2'h0) & (paddr_i <= OFS_IRQ_EN);
   assign pready_o = access;
   assign pslverr_o = access & ~mapped;
   assign prdata_o = rdata_q;
   assign rsel = (paddr_i == OFS_STATUS_A) ? {16'h0000, status_a_q} :
                 (paddr_i == OFS_STATUS_B) ? {16'h0000, status_b_q} :
                 (paddr_i == OFS_OPERAND) ? {16'h0000, operand_q} :
                 (paddr_i == OFS_PRODUCT) ? product_q :
                 (paddr_i == OFS_ACC) ? acc_q :
                 (paddr_i == OFS_IRQ_STAT) ? {30'h0, irq_stat_q} :
                 (paddr_i == OFS_IRQ_EN) ? {30'h0, irq_en_q} : 32'h0;
   logic wr_sa, wr_sb, wr_op, wr_clr, wr_en;
   assign wr_sa = wr & (paddr_i == OFS_STATUS_A);
   assign wr_sb = wr & (paddr_i == OFS_STATUS_B);
   assign wr_op = wr & (paddr_i == OFS_OPERAND);
   assign wr_clr = wr & (paddr_i == OFS_IRQ_CLR);
   assign wr_en = wr & (paddr_i == OFS_IRQ_EN);

   // =====================================================
   // next state
   logic [15:0] sa_base, sb_base;
   logic tc_set;
   logic [EV_W-1:0] events;
   // a status write from apb and a status load from memory both count as explicit writes
   assign sa_base = wr_sa ? pwdata_i[15:0] : do_ld_a ? op_data_i : status_a_q;
   assign sb_base = wr_sb ? pwdata_i[15:0] : do_ld_b ? op_data_i : status_b_q;
   assign tc_set = do_bit & bit_val;
   assign events = {tc_set, ovf};

   always_comb begin
      status_a_d = sa_base;
      // overflow sticks; an event in the clearing cycle wins
      status_a_d[POS_OV] = ovf | (sa_base[POS_OV] & ~do_clr_ov);
      status_b_d = sb_base;
      if (do_bit) begin
         status_b_d[POS_TC] = bit_val;
      end
   end

   assign operand_d = do_ldop ? op_data_i : wr_op ? pwdata_i[15:0] : operand_q;
   assign product_d = do_mul ? product : product_q;
   assign acc_d = do_load ? dp.in_result :
                  (ovf & saturate_enable) ? sat_val :
                  arith ? sum[31:0] :
                  do_shacc ? shacc : acc_q;
   assign wbus_d = do_store ? dp.out_word : do_st_a ? status_a_q : do_st_b ? status_b_q : wbus_q;
   assign irq_stat_d = (irq_stat_q & ~(wr_clr ? pwdata_i[EV_W-1:0] : {EV_W{1'b0}})) | events;
   assign irq_en_d = wr_en ? pwdata_i[EV_W-1:0] : irq_en_q;

   // =====================================================
   // registers
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         status_a_q <= RST_STATUS_A;
         status_b_q <= RST_STATUS_B;
         operand_q <= 16'h0000;
         product_q <= 32'h00000000;
         acc_q <= 32'h00000000;
      end else if (ce_i) begin
         status_a_q <= status_a_d;
         status_b_q <= status_b_d;
         operand_q <= operand_d;
         product_q <= product_d;
         acc_q <= acc_d;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wbus_q <= 16'h0000;
         wvalid_q <= 1'b0;
         irq_stat_q <= '0;
         irq_en_q <= RST_IRQ_EN;
         rdata_q <= 32'h00000000;
      end else if (ce_i) begin
         wbus_q <= wbus_d;
         wvalid_q <= do_store | do_st_a | do_st_b;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         rdata_q <= setup ? rsel : rdata_q;
      end
   end

   assign data_write_bus_o = wbus_q;
   assign data_write_valid_o = wvalid_q;
   assign acc_o = acc_q;
   assign test_flag_o = status_b_q[POS_TC];
   assign overflow_flag_o = ov;
   assign irq_o = |(irq_stat_q & irq_en_q);

   // =====================================================
   // checks
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_store_req;
      do_store;
   endsequence
   sequence s_store_out(logic [15:0] w);
      data_write_valid_o && data_write_bus_o == w;
   endsequence

   prod_left1_a: assert property (pm == PM_LEFT1 |-> dp.prod_shifted == {product_q[30:0], 1'b0})
      else $error("product shift left by one wrong");
   prod_right6_a: assert property (pm == PM_RIGHT6 |-> dp.prod_shifted[25:0] == product_q[31:6])
      else $error("product shift right by six wrong");
   prod_capture_a: assert property (do_mul |=> product_q == $past(product))
      else $error("product register missed multiply");
   store_word_a: assert property (s_store_req |=> s_store_out($past(dp.out_word)))
      else $error("stored word wrong");
   sat_limit_a: assert property (ovf && saturate_enable && !do_load |=> acc_q == ($past(sum[32]) ? ACC_MIN : ACC_MAX))
      else $error("saturation value wrong");
   wrap_nosat_a: assert property (ovf && !saturate_enable |=> acc_q == $past(sum[31:0]))
      else $error("accumulator saturated with mode off");
   ov_set_a: assert property (ovf |=> overflow_flag_o)
      else $error("overflow flag not set");
   ov_sticky_a: assert property (ov && ce_i && !wr_sa && !do_ld_a && !do_clr_ov |=> overflow_flag_o)
      else $error("overflow flag dropped");
   tc_record_a: assert property (do_bit |=> test_flag_o == $past(bit_val))
      else $error("test flag not recorded");

   // =====================================================
   // shifter, multiplier and status word checks
   sequence s_mul_req(logic sg);
      do_mul && op_sel_i == sg;
   endsequence

   prod_left4_a: assert property (pm == PM_LEFT4 |-> dp.prod_shifted == {product_q[27:0], 4'h0})
      else $error("product shift left by four wrong");
   prod_none_a: assert property (pm == PM_NONE |-> dp.prod_shifted == product_q)
      else $error("product passed with a shift");
   prod_fill6_a: assert property (pm == PM_RIGHT6 |-> dp.prod_shifted[31:26] == {6{product_q[31]}})
      else $error("product right shift lost its sign");
   pm_write_a: assert property (wr_sb |=> pm == $past(pwdata_i[1:0]))
      else $error("product shift select not written");
   sign_fill_a: assert property (sign_extend_enable |-> dp.in_result[31] == dp.in_word[15])
      else $error("input shift not sign filled");
   zero_high_a: assert property (!sign_extend_enable && dp.in_count == 5'h00 |-> dp.in_result[31:16] == 16'h0000)
      else $error("input shift high bits not zero");
   zero_low_a: assert property (dp.in_count >= IN_SHIFT_MAX |-> dp.in_result[15:0] == 16'h0000)
      else $error("input shift low bits not zero");
   in_shift16_a: assert property (dp.in_count >= IN_SHIFT_MAX |-> dp.in_result[31:16] == dp.in_word)
      else $error("input shift by sixteen wrong");
   mul_unsigned_a: assert property (s_mul_req(1'b0) |=>
      product_q == $past(op_data_i) * $past(operand_q))
      else $error("unsigned product wrong");
   mul_signed_a: assert property (s_mul_req(1'b1) |=>
      $signed(product_q) == $signed($past(op_data_i)) * $signed($past(operand_q)))
      else $error("signed product wrong");
   operand_load_a: assert property (do_ldop |=> operand_q == $past(op_data_i))
      else $error("operand register not loaded");
   sta_store_a: assert property (do_st_a |=> s_store_out($past(status_a_q)))
      else $error("status a not stored");
   stb_store_a: assert property (do_st_b |=> s_store_out($past(status_b_q)))
      else $error("status b not stored");
   sta_load_a: assert property (do_ld_a |=> status_a_q[11:0] == $past(op_data_i[11:0]))
      else $error("status a not loaded");
   shacc_right_a: assert property (do_shacc && op_sel_i |=>
      acc_q == {$past(sign_extend_enable & acc_q[31]), $past(acc_q[31:1])})
      else $error("accumulator right shift wrong");
   shacc_left_a: assert property (do_shacc && !op_sel_i |=> acc_q == {$past(acc_q[30:0]), 1'b0})
      else $error("accumulator left shift wrong");
endmodule : asp_core

// >>> sim/asp_decode_model.sv
// behavioural decode side of the datapath: drives one op per call
// assumes the bench calls issue and idle from one process, one call per edge
module asp_decode_model (
   input wire logic clk_i, // core clock
   output logic op_valid_o, // op strobe
   output asp_pkg::asp_op_type op_code_o, // operation
   output logic [15:0] op_data_o, // operand word
   output logic [4:0] op_shift_o, // static count
   output logic op_sel_o // qualifier
);
   timeunit 1ns;
   timeprecision 1ps;
   import asp_pkg::*;

   initial begin
      op_valid_o = 1'b0;
      op_code_o = OP_LOAD_OPERAND;
      op_data_o = 16'h0000;
      op_shift_o = 5'h00;
      op_sel_o = 1'b0;
   end

   // =====================================================
   // requests change just after an edge and hold until the next one
   task automatic issue(input asp_op_type op, input logic [15:0] d, input logic [4:0] s, input logic sel);
      @(posedge clk_i);
      op_valid_o <= 1'b1;
      op_code_o <= op;
      op_data_o <= d;
      op_shift_o <= s;
      op_sel_o <= sel;
   endtask : issue

   // released data, shift and select lines flip so a stale value is never mistaken for a live one
   task automatic idle();
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      op_data_o <= ~op_data_o;
      op_shift_o <= ~op_shift_o;
      op_sel_o <= ~op_sel_o;
   endtask : idle
endmodule : asp_decode_model

// >>> sim/accumulator_shift_saturate_path_tb.sv
// self-checking bench of the accumulator, shift and saturate datapath
// assumes asp_core answers ops one edge later and apb with zero wait states
module accumulator_shift_saturate_path_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import asp_pkg::*;
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end

   logic sys_clk_i = 1'b0, sys_rst_i = 1'b1, ce_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0, prdata_o, acc_o;
   logic pready_o, pslverr_o, irq_o, test_flag_o, overflow_flag_o, data_write_valid_o;
   logic [15:0] data_write_bus_o, op_data;
   logic op_valid, op_sel;
   logic [4:0] op_shift;
   asp_op_type op_code;
   int bad_count = 0, cmp_count = 0;
   integer seed = 32'h0659;
   // =====================================================
   // reference state
   logic [31:0] m_acc = 32'h0, m_prod = 32'h0;
   logic [15:0] m_sa = 16'h0, m_sb = 16'h0, m_opr = 16'h0, m_bus = 16'h0;
   logic [1:0] m_ist = 2'h0, m_ien = 2'h0;
   logic m_wv = 1'b0;
   // every decoded op is drawn at random; accumulator shifts move one place
   asp_op_type ops [14] = '{OP_LOAD_OPERAND, OP_MUL, OP_LOAD_ACC, OP_ADD, OP_SUB, OP_ADD_PROD, OP_STORE_ACC,
      OP_BIT_TEST, OP_STORE_ST_A, OP_STORE_ST_B, OP_LOAD_ST_A, OP_LOAD_ST_B, OP_CLEAR_OV, OP_SHIFT_ACC};

   asp_decode_model i_dec (.clk_i(sys_clk_i), .op_valid_o(op_valid), .op_code_o(op_code), .op_data_o(op_data),
      .op_shift_o(op_shift), .op_sel_o(op_sel));
   asp_core i_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .op_valid_i(op_valid),
      .op_code_i(op_code), .op_data_i(op_data), .op_shift_i(op_shift), .op_sel_i(op_sel),
      .data_write_bus_o(data_write_bus_o), .data_write_valid_o(data_write_valid_o), .acc_o(acc_o),
      .test_flag_o(test_flag_o), .overflow_flag_o(overflow_flag_o), .irq_o(irq_o), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o));

   initial begin
      forever #2 sys_clk_i = ~sys_clk_i;
   end

   // =====================================================
   // reference model
   task automatic add_sum(input longint t);
      if (t > 64'sh7fffffff || t < -64'sh80000000) begin
         m_sa[POS_OV] = 1'b1;
         m_ist[EV_OV] = 1'b1;
         m_acc = m_sa[POS_OVM] ? ((t > 0) ? ACC_MAX : ACC_MIN) : t[31:0];
      end else begin
         m_acc = t[31:0];
      end
   endtask : add_sum

   task automatic apply(input asp_op_type op, input logic [15:0] d, input logic [4:0] s, input logic sel);
      logic [4:0] c;
      logic [31:0] v, pv, w;
      logic [3:0] ix;
      c = sel ? {1'b0, m_opr[3:0]} : ((s > IN_SHIFT_MAX) ? IN_SHIFT_MAX : s);
      v = (m_sb[POS_SXM] ? {{16{d[15]}}, d} : {16'h0000, d}) << c;
      case (m_sb[1:0])
         PM_NONE: pv = m_prod;
         PM_LEFT1: pv = m_prod << 1;
         PM_LEFT4: pv = m_prod << 4;
         default: pv = $signed(m_prod) >>> 6;
      endcase
      w = m_acc << s[2:0];
      ix = sel ? m_opr[3:0] : s[3:0];
      m_wv = 1'b0;
      case (op)
         OP_LOAD_OPERAND: m_opr = d;
         OP_MUL: m_prod = sel ? {{16{d[15]}}, d} * {{16{m_opr[15]}}, m_opr} : {16'h0000, d} * {16'h0000, m_opr};
         OP_LOAD_ACC: m_acc = v;
         OP_ADD: add_sum(longint'($signed(m_acc)) + longint'($signed(v)));
         OP_SUB: add_sum(longint'($signed(m_acc)) - longint'($signed(v)));
         OP_ADD_PROD: add_sum(longint'($signed(m_acc)) + longint'($signed(pv)));
         OP_SHIFT_ACC: m_acc = sel ? {m_sb[POS_SXM] & m_acc[31], m_acc[31:1]} : {m_acc[30:0], 1'b0};
         OP_STORE_ACC: begin
            m_bus = sel ? w[31:16] : w[15:0];
            m_wv = 1'b1;
         end
         OP_BIT_TEST: begin
            m_sb[POS_TC] = d[ix];
            if (d[ix]) m_ist[EV_TC] = 1'b1;
         end
         OP_STORE_ST_A: begin
            m_bus = m_sa;
            m_wv = 1'b1;
         end
         OP_STORE_ST_B: begin
            m_bus = m_sb;
            m_wv = 1'b1;
         end
         OP_LOAD_ST_A: m_sa = d;
         OP_LOAD_ST_B: m_sb = d;
         OP_CLEAR_OV: m_sa[POS_OV] = 1'b0;
         default: ;
      endcase
   endtask : apply

   task automatic chk_state();
      `CHK(acc_o, m_acc)
      `CHK(overflow_flag_o, m_sa[POS_OV])
      `CHK(test_flag_o, m_sb[POS_TC])
      `CHK(irq_o, |(m_ist & m_ien))
      `CHK(data_write_valid_o, m_wv)
      if (m_wv) `CHK(data_write_bus_o, m_bus)
   endtask : chk_state

   // checks the op taken at this edge, then books the new one
   task automatic do_op(input asp_op_type op, input logic [15:0] d, input logic [4:0] s, input logic sel,
      input logic ce);
      i_dec.issue(op, d, s, sel);
      ce_i <= ce;
      #1;
      chk_state();
      if (ce) apply(op, d, s, sel);
   endtask : do_op

   task automatic do_idle();
      i_dec.idle();
      ce_i <= 1'b1;
      #1;
      chk_state();
      m_wv = 1'b0;
   endtask : do_idle

   // =====================================================
   // apb master
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      int n;
      @(posedge sys_clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= wd;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         test_done();
      end
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      `CHK(r, x)
      `CHK(e, xe)
   endtask : rd_chk

   task automatic test_done();
      $display("TB: %0d mismatches in %0d compares", bad_count, cmp_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : test_done

   initial begin
      #100000;
      bad_count++;
      test_done();
   end

   // =====================================================
   // scenarios
   initial begin
      asp_op_type o;
      logic ce;
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      rd_chk(OFS_STATUS_A, {16'h0000, RST_STATUS_A}, 1'b0);
      rd_chk(OFS_STATUS_B, {16'h0000, RST_STATUS_B}, 1'b0);
      rd_chk(8'h20, 32'h0, 1'b1);
      wr(OFS_IRQ_EN, 32'h3);
      m_ien = 2'h3;
      for (int p = 0; p < 4; p++) begin
         wr(OFS_STATUS_B, 32'(p));
         m_sb = 16'(p);
         do_op(OP_LOAD_OPERAND, 16'($random(seed)), 5'h00, 1'b0, 1'b1);
         do_op(OP_MUL, 16'($random(seed)), 5'h00, p[0], 1'b1);
         do_op(OP_LOAD_ACC, 16'h0000, 5'h00, 1'b0, 1'b1);
         do_op(OP_ADD_PROD, 16'h0000, 5'h00, 1'b0, 1'b1);
         do_idle();
         rd_chk(OFS_PRODUCT, m_prod, 1'b0);
      end
      wr(OFS_STATUS_A, 32'h0800);
      m_sa = 16'h0800;
      do_op(OP_LOAD_ACC, 16'h7fff, 5'h10, 1'b0, 1'b1);
      do_op(OP_ADD, 16'h7fff, 5'h10, 1'b0, 1'b1);
      do_op(OP_SUB, 16'h0001, 5'h00, 1'b0, 1'b1);
      do_op(OP_LOAD_ST_B, 16'h0400, 5'h00, 1'b0, 1'b1);
      do_op(OP_LOAD_ACC, 16'h8000, 5'h10, 1'b0, 1'b1);
      do_op(OP_SUB, 16'h7fff, 5'h10, 1'b0, 1'b1);
      do_op(OP_CLEAR_OV, 16'h0000, 5'h00, 1'b0, 1'b1);
      do_op(OP_LOAD_ST_A, 16'h0000, 5'h00, 1'b0, 1'b1);
      do_op(OP_SUB, 16'h7fff, 5'h10, 1'b0, 1'b1);
      do_op(OP_STORE_ACC, 16'h0000, 5'h07, 1'b1, 1'b1);
      do_op(OP_STORE_ACC, 16'h0000, 5'h07, 1'b0, 1'b1);
      do_op(OP_LOAD_OPERAND, 16'h0005, 5'h00, 1'b0, 1'b1);
      do_op(OP_BIT_TEST, 16'h0020, 5'h00, 1'b1, 1'b1);
      do_idle();
      rd_chk(OFS_IRQ_STAT, {30'h0, m_ist}, 1'b0);
      wr(OFS_IRQ_CLR, 32'h3);
      m_ist = 2'h0;
      rd_chk(OFS_IRQ_STAT, 32'h0, 1'b0);
      // a frozen cycle right after a store would stretch its strobe, so never there
      for (int i = 0; i < 80; i++) begin
         o = ops[$unsigned($random(seed)) % 14];
         ce = m_wv || (($random(seed) & 3) != 0);
         do_op(o, 16'($random(seed)), 5'($random(seed)), 1'($random(seed)), ce);
      end
      do_idle();
      rd_chk(OFS_STATUS_A, {16'h0000, m_sa}, 1'b0);
      rd_chk(OFS_STATUS_B, {16'h0000, m_sb}, 1'b0);
      test_done();
   end
endmodule : accumulator_shift_saturate_path_tb
